/* File: core/wdcp_pkg.sv */
package wdcp_pkg;

  // Bus widths
  localparam int C_DATA_W = 8;
  localparam int C_ADDR_W = 4;

  // Register offsets
  localparam logic [C_ADDR_W-1:0] C_ADDR_CTRL = 4'h0;
  localparam logic [C_ADDR_W-1:0] C_ADDR_STAT = 4'h1;
  localparam logic [C_ADDR_W-1:0] C_ADDR_MASK = 4'h2;
  localparam logic [C_ADDR_W-1:0] C_ADDR_INFO = 4'h3;

  // Field widths and reset values
  localparam int C_SEL_W = 3;
  localparam logic [C_SEL_W-1:0] C_SEL_RST = 3'h0;
  localparam logic C_WDE_RST = 1'h0;
  localparam logic [C_DATA_W-1:0] C_RDATA_RST = 8'h00;

  // Unlock window in core clock cycles
  localparam int C_WIN_W = 3;
  localparam logic [C_WIN_W-1:0] C_UNLOCK_CYCLES = 3'h4;
  localparam logic [C_WIN_W-1:0] C_WIN_LAST = 3'h1;
  localparam logic [C_WIN_W-1:0] C_WIN_IDLE = 3'h0;

  // Time-out in watchdog oscillator cycles
  localparam int C_BASE_OSC_CYCLES = 16384;
  localparam int C_CNT_W = 22;
  localparam logic [C_CNT_W-1:0] C_CNT_ZERO = 22'h000000;
  localparam logic [C_CNT_W-1:0] C_CNT_ONE = 22'h000001;

  // Fuse settle cycles after reset release
  localparam logic [1:0] C_SETTLE_CYCLES = 2'h2;
  localparam logic [1:0] C_SETTLE_RST = 2'h0;
  localparam logic [1:0] C_SETTLE_STEP = 2'h1;

  // Event bit positions in status and mask
  localparam int C_EV_W = 4;
  localparam int C_EV_TIMEOUT = 0;
  localparam int C_EV_ARMED = 1;
  localparam int C_EV_APPLIED = 2;
  localparam int C_EV_REJECT = 3;
  localparam logic [C_EV_W-1:0] C_EV_NONE = 4'h0;

  // Synchroniser lanes
  localparam int C_SYNC_W = 3;
  localparam int C_LANE_OSC = 0;
  localparam int C_LANE_COMPAT = 1;
  localparam int C_LANE_ALWAYS = 2;

  // Safety levels
  typedef enum logic [1:0] {
    WDCP_LVL0 = 2'b00,
    WDCP_LVL1 = 2'b01,
    WDCP_LVL2 = 2'b10
  } wdcp_level_t;

  // Unlock state
  typedef enum logic [0:0] {
    WDCP_ST_LOCKED = 1'b0,
    WDCP_ST_OPEN = 1'b1
  } wdcp_unlock_t;

  // Control register layout
  typedef struct packed {
    logic [2:0] reserved;
    logic change_enable;
    logic watchdog_enable;
    logic [C_SEL_W-1:0] timeout_prescale_select;
  } wdcp_ctrl_t;

  // Info register layout
  typedef struct packed {
    logic [2:0] reserved;
    logic level_valid;
    wdcp_level_t level;
    logic window_open;
    logic running;
  } wdcp_info_t;

  // Register bus request
  typedef struct packed {
    logic [C_ADDR_W-1:0] addr;
    logic [C_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wdcp_bus_t;

endpackage : wdcp_pkg

/* File: core/wdcp_sync.sv */
module wdcp_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= '0;
      o_sync <= '0;
    end else if (i_clk_en) begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : wdcp_sync

/* File: core/wdcp_top.sv */
module wdcp_top #(
  parameter int P_BASE_OSC_CYCLES = wdcp_pkg::C_BASE_OSC_CYCLES
) (
  // Clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_CLK_EN,
  // Register port
  input wire logic [wdcp_pkg::C_ADDR_W-1:0] I_ADDR,
  input wire logic [wdcp_pkg::C_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [wdcp_pkg::C_DATA_W-1:0] O_RDATA,
  // Core restart strobe and watchdog oscillator
  input wire logic I_WATCHDOG_RESTART_INSTR,
  input wire logic I_WDT_OSC,
  // Fuses, high when programmed
  input wire logic I_LEGACY_COMPAT_FUSE,
  input wire logic I_ALWAYS_ON_FUSE,
  // Status outputs
  output logic O_WDT_RESET,
  output logic O_WDT_ENABLED,
  output logic [wdcp_pkg::C_SEL_W-1:0] O_TIMEOUT_SEL,
  output logic O_IRQ
);

  // Bus request bundle
  wdcp_pkg::wdcp_bus_t bus;
  wdcp_pkg::wdcp_ctrl_t wctl;

  // Synchronised pins
  logic [wdcp_pkg::C_SYNC_W-1:0] pins_async;
  logic [wdcp_pkg::C_SYNC_W-1:0] pins_sync;
  logic osc_prev, osc_tick;

  // Safety level capture
  logic [1:0] settle;
  logic level_valid;
  wdcp_pkg::wdcp_level_t level;
  wdcp_pkg::wdcp_level_t next_level;

  // Control fields
  logic watchdog_enable;
  logic [wdcp_pkg::C_SEL_W-1:0] timeout_prescale_select;
  logic next_wde;
  logic [wdcp_pkg::C_SEL_W-1:0] next_sel;
  logic reject, wdt_on;

  // Unlock window
  wdcp_pkg::wdcp_unlock_t unlock_state;
  logic [wdcp_pkg::C_WIN_W-1:0] window;
  logic window_open, wr_ctrl, arm, commit;

  // Time-out counter
  logic [wdcp_pkg::C_CNT_W-1:0] cnt, limit;
  logic run, expire;

  // Status and mask
  logic [wdcp_pkg::C_EV_W-1:0] stat;
  logic [wdcp_pkg::C_EV_W-1:0] mask;
  logic [wdcp_pkg::C_EV_W-1:0] events;
  logic [wdcp_pkg::C_EV_W-1:0] next_stat;
  wdcp_pkg::wdcp_info_t info;

  // Bundle the register port
  assign bus = {I_ADDR, I_WDATA, I_WR, I_RD};
  assign wctl = wdcp_pkg::wdcp_ctrl_t'(bus.wdata);

  // Pins from outside pass two flip-flops
  assign pins_async[wdcp_pkg::C_LANE_OSC] = I_WDT_OSC;
  assign pins_async[wdcp_pkg::C_LANE_COMPAT] = I_LEGACY_COMPAT_FUSE;
  assign pins_async[wdcp_pkg::C_LANE_ALWAYS] = I_ALWAYS_ON_FUSE;

  wdcp_sync #(
    .W(wdcp_pkg::C_SYNC_W)
  ) u_sync (
    .i_clk(I_CORE_CLK),
    .i_nrst(I_NRST),
    .i_clk_en(I_CLK_EN),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  // Rising edge of the watchdog oscillator
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      osc_prev <= 1'b0;
    end else if (I_CLK_EN) begin
      osc_prev <= pins_sync[wdcp_pkg::C_LANE_OSC];
    end
  end

  assign osc_tick = pins_sync[wdcp_pkg::C_LANE_OSC] & ~osc_prev;

  // Fuse decode into a safety level
  always_comb begin
    if (pins_sync[wdcp_pkg::C_LANE_ALWAYS]) begin
      next_level = wdcp_pkg::WDCP_LVL2;
    end else if (pins_sync[wdcp_pkg::C_LANE_COMPAT]) begin
      next_level = wdcp_pkg::WDCP_LVL0;
    end else begin
      next_level = wdcp_pkg::WDCP_LVL1;
    end
  end

  // Capture the level once the synchroniser has filled
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      settle <= wdcp_pkg::C_SETTLE_RST;
      level_valid <= 1'b0;
      level <= wdcp_pkg::WDCP_LVL1;
    end else if (I_CLK_EN) begin
      if (!level_valid) begin
        if (settle == wdcp_pkg::C_SETTLE_CYCLES) begin
          level_valid <= 1'b1;
          level <= next_level;
        end else begin
          settle <= settle + wdcp_pkg::C_SETTLE_STEP;
        end
      end
    end
  end

  // Write decode for the control register
  assign wr_ctrl = bus.wr & (bus.addr == wdcp_pkg::C_ADDR_CTRL);
  assign window_open = (unlock_state == wdcp_pkg::WDCP_ST_OPEN);
  // Arming needs both bits in one write
  assign arm = wr_ctrl & wctl.change_enable & wctl.watchdog_enable;
  // One write with change enable cleared uses the window
  assign commit = wr_ctrl & window_open & ~wctl.change_enable;

  // Field update per safety level
  always_comb begin
    next_wde = watchdog_enable;
    next_sel = timeout_prescale_select;
    reject = 1'b0;
    if (wr_ctrl) begin
      case (level)
        wdcp_pkg::WDCP_LVL0: begin
          next_sel = wctl.timeout_prescale_select;
          if (wctl.watchdog_enable) begin
            next_wde = 1'b1;
          end else if (commit) begin
            next_wde = 1'b0;
          end else if (watchdog_enable) begin
            reject = 1'b1;
          end
        end
        wdcp_pkg::WDCP_LVL1: begin
          if (commit) begin
            next_wde = wctl.watchdog_enable;
            next_sel = wctl.timeout_prescale_select;
          end else begin
            if (wctl.watchdog_enable) begin
              next_wde = 1'b1;
            end else if (watchdog_enable) begin
              reject = 1'b1;
            end
            if (wctl.timeout_prescale_select != timeout_prescale_select) begin
              reject = 1'b1;
            end
          end
        end
        wdcp_pkg::WDCP_LVL2: begin
          next_wde = 1'b1;
          if (commit) begin
            next_sel = wctl.timeout_prescale_select;
          end else if (wctl.timeout_prescale_select !=
                       timeout_prescale_select) begin
            reject = 1'b1;
          end
        end
        default: begin
          next_wde = watchdog_enable;
        end
      endcase
    end
  end

  // Enable and prescaler fields
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      watchdog_enable <= wdcp_pkg::C_WDE_RST;
      timeout_prescale_select <= wdcp_pkg::C_SEL_RST;
    end else if (I_CLK_EN) begin
      watchdog_enable <= next_wde;
      timeout_prescale_select <= next_sel;
    end
  end

  // Level 2 forces the watchdog on
  assign wdt_on = (level == wdcp_pkg::WDCP_LVL2) | watchdog_enable;

  // Unlock window, open for four cycles after arming
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      unlock_state <= wdcp_pkg::WDCP_ST_LOCKED;
      window <= wdcp_pkg::C_WIN_IDLE;
    end else if (I_CLK_EN) begin
      case (unlock_state)
        wdcp_pkg::WDCP_ST_LOCKED: begin
          if (arm) begin
            unlock_state <= wdcp_pkg::WDCP_ST_OPEN;
            window <= wdcp_pkg::C_UNLOCK_CYCLES;
          end
        end
        wdcp_pkg::WDCP_ST_OPEN: begin
          if (arm) begin
            window <= wdcp_pkg::C_UNLOCK_CYCLES;
          end else if (commit || window == wdcp_pkg::C_WIN_LAST) begin
            unlock_state <= wdcp_pkg::WDCP_ST_LOCKED;
            window <= wdcp_pkg::C_WIN_IDLE;
          end else begin
            window <= window - wdcp_pkg::C_WIN_LAST;
          end
        end
        default: begin
          unlock_state <= wdcp_pkg::WDCP_ST_LOCKED;
          window <= wdcp_pkg::C_WIN_IDLE;
        end
      endcase
    end
  end

  // Time-out length doubles per prescaler step
  assign limit = wdcp_pkg::C_CNT_W'(P_BASE_OSC_CYCLES) <<
                 timeout_prescale_select;
  assign run = level_valid & wdt_on;
  assign expire = run & osc_tick & (cnt == limit - wdcp_pkg::C_CNT_ONE);

  // Watchdog counter on oscillator edges
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      cnt <= wdcp_pkg::C_CNT_ZERO;
    end else if (I_CLK_EN) begin
      if (!run || I_WATCHDOG_RESTART_INSTR) begin
        cnt <= wdcp_pkg::C_CNT_ZERO;
      end else if (expire) begin
        cnt <= wdcp_pkg::C_CNT_ZERO;
      end else if (osc_tick) begin
        cnt <= cnt + wdcp_pkg::C_CNT_ONE;
      end
    end
  end

  // Event collection
  always_comb begin
    events = wdcp_pkg::C_EV_NONE;
    events[wdcp_pkg::C_EV_TIMEOUT] = expire & ~I_WATCHDOG_RESTART_INSTR;
    events[wdcp_pkg::C_EV_ARMED] = arm;
    events[wdcp_pkg::C_EV_APPLIED] = commit;
    events[wdcp_pkg::C_EV_REJECT] = reject;
  end

  // Read clears status, a new event wins
  always_comb begin
    next_stat = stat;
    if (bus.rd && bus.addr == wdcp_pkg::C_ADDR_STAT) begin
      next_stat = wdcp_pkg::C_EV_NONE;
    end
    next_stat = next_stat | events;
  end

  // Sticky status
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      stat <= wdcp_pkg::C_EV_NONE;
    end else if (I_CLK_EN) begin
      stat <= next_stat;
    end
  end

  // Interrupt mask
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      mask <= wdcp_pkg::C_EV_NONE;
    end else if (I_CLK_EN) begin
      if (bus.wr && bus.addr == wdcp_pkg::C_ADDR_MASK) begin
        mask <= bus.wdata[wdcp_pkg::C_EV_W-1:0];
      end
    end
  end

  // Info view of the block state
  always_comb begin
    info = '0;
    info.level_valid = level_valid;
    info.level = level;
    info.window_open = window_open;
    info.running = run;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_RDATA <= wdcp_pkg::C_RDATA_RST;
    end else if (I_CLK_EN) begin
      O_RDATA <= wdcp_pkg::C_RDATA_RST;
      if (bus.rd) begin
        case (bus.addr)
          wdcp_pkg::C_ADDR_CTRL: begin
            O_RDATA <= {3'h0, window_open, wdt_on,
                        timeout_prescale_select};
          end
          wdcp_pkg::C_ADDR_STAT: begin
            O_RDATA <= {4'h0, stat};
          end
          wdcp_pkg::C_ADDR_MASK: begin
            O_RDATA <= {4'h0, mask};
          end
          wdcp_pkg::C_ADDR_INFO: begin
            O_RDATA <= info;
          end
          default: begin
            O_RDATA <= wdcp_pkg::C_RDATA_RST;
          end
        endcase
      end
    end
  end

  // Registered outputs
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_WDT_RESET <= 1'b0;
      O_WDT_ENABLED <= 1'b0;
      O_TIMEOUT_SEL <= wdcp_pkg::C_SEL_RST;
      O_IRQ <= 1'b0;
    end else if (I_CLK_EN) begin
      O_WDT_RESET <= expire & ~I_WATCHDOG_RESTART_INSTR;
      O_WDT_ENABLED <= run;
      O_TIMEOUT_SEL <= timeout_prescale_select;
      O_IRQ <= |(next_stat & mask);
    end
  end

endmodule : wdcp_top

/* File: verification/test_watchdog_config_protection.sv */
module test_watchdog_config_protection;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 4;
  logic clk, nrst, restart, compat, always_on, wd_rst, wd_en, irq;
  logic osc = 1'b0;
  logic [2:0] sel;
  logic [7:0] rdata, rd_val;
  logic [15:0] seed = 16'h2CBE;
  wdcp_pkg::wdcp_bus_t bus;
  int n_fail, checked, lvl, exp_wde, exp_sel, since, n, cnt, exp_n;
  int div = 0;

  wdcp_top #(.P_BASE_OSC_CYCLES(P)) i_dut (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_CLK_EN(1'b1),
    .I_ADDR(bus.addr), .I_WDATA(bus.wdata), .I_WR(bus.wr), .I_RD(bus.rd),
    .O_RDATA(rdata), .I_WATCHDOG_RESTART_INSTR(restart), .I_WDT_OSC(osc),
    .I_LEGACY_COMPAT_FUSE(compat), .I_ALWAYS_ON_FUSE(always_on),
    .O_WDT_RESET(wd_rst), .O_WDT_ENABLED(wd_en), .O_TIMEOUT_SEL(sel),
    .O_IRQ(irq)
  );
  wdcp_sw i_sw (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

  // Core clock and watchdog oscillator, six core cycles a period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (div == 2) begin
      div <= 0;
      osc <= ~osc;
    end else div <= div + 1;
  end

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Reset with fuses set for a safety level
  task automatic boot(input int l);
    lvl = l;
    compat <= (l == 0);
    always_on <= (l == 2);
    nrst <= 1'b0;
    exp_wde = (l == 2);
    exp_sel = 0;
    since = 99;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : boot

  // Control write with the reference model of the unlock rules
  task automatic s(input logic [7:0] d, input int g);
    since++;
    i_sw.wr(wdcp_pkg::C_ADDR_CTRL, d);
    if (d[4] && d[3]) begin
      since = 0;
      if (lvl != 2) exp_wde = 1;
      if (lvl == 0) exp_sel = d[2:0];
    end else if (!d[4] && since <= 4) begin
      since = 99;
      exp_sel = d[2:0];
      if (lvl != 2) exp_wde = d[3];
    end else if (lvl == 0) begin
      exp_sel = d[2:0];
      exp_wde |= d[3];
    end else if (lvl == 1) exp_wde |= d[3];
    i_sw.idle(g);
    since += g;
  endtask : s

  // Control read back and pins against the model
  task automatic cmp_ctrl();
    i_sw.rd(wdcp_pkg::C_ADDR_CTRL, rd_val);
    chk(rd_val, {4'h0, exp_wde[0], exp_sel[2:0]});
    chk({4'h0, wd_en, sel}, {4'h0, exp_wde[0], exp_sel[2:0]});
  endtask : cmp_ctrl

  task automatic to_pulse();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wd_rst !== 1'b1 && n < 500);
  endtask : to_pulse

  // Main sequence
  initial begin
    restart <= 1'b0;
    boot(1);
    cmp_ctrl();
    s(8'h05, 1);
    cmp_ctrl();
    i_sw.rd(wdcp_pkg::C_ADDR_STAT, rd_val);
    chk(rd_val, 8'h08);
    s(8'h08, 1);
    cmp_ctrl();
    s(8'h00, 1);
    cmp_ctrl();
    s(8'h18, 4);
    s(8'h03, 1);
    cmp_ctrl();
    s(8'h18, 3);
    s(8'h03, 1);
    cmp_ctrl();
    s(8'h1B, 2);
    s(8'h1B, 3);
    s(8'h0C, 1);
    cmp_ctrl();
    $display("test level1 done");
    boot(0);
    cmp_ctrl();
    i_sw.rd(wdcp_pkg::C_ADDR_INFO, rd_val);
    chk(rd_val, 8'h10);
    for (int i = 0; i < 4; i++) begin
      seed = nx(seed);
      s({5'h00, seed[2:0]}, 1);
      cmp_ctrl();
    end
    i_sw.wr(4'h9, seed[15:8]);
    i_sw.rd(4'h9, rd_val);
    chk(rd_val, 8'h00);
    s(8'h08, 1);
    s(8'h00, 1);
    cmp_ctrl();
    s({5'h03, exp_sel[2:0]}, 0);
    s(8'h00, 1);
    cmp_ctrl();
    $display("test level0 done");
    boot(2);
    cmp_ctrl();
    i_sw.rd(wdcp_pkg::C_ADDR_INFO, rd_val);
    chk(rd_val, 8'h19);
    s(8'h05, 1);
    cmp_ctrl();
    s(8'h18, 0);
    s(8'h02, 1);
    cmp_ctrl();
    to_pulse();
    to_pulse();
    exp_n = (P << 2) * 6;
    chk(n[7:0], exp_n[7:0]);
    cnt = 0;
    for (int i = 0; i < 300; i++) begin
      restart <= (i % 48 == 0);
      @(posedge clk);
      if (wd_rst === 1'b1) cnt++;
    end
    restart <= 1'b0;
    chk(cnt[7:0], 8'h00);
    to_pulse();
    i_sw.wr(wdcp_pkg::C_ADDR_MASK, 8'h01);
    i_sw.idle(2);
    chk({7'h00, irq}, 8'h01);
    i_sw.rd(wdcp_pkg::C_ADDR_STAT, rd_val);
    chk(rd_val & 8'h01, 8'h01);
    i_sw.rd(wdcp_pkg::C_ADDR_STAT, rd_val);
    chk(rd_val & 8'h01, 8'h00);
    chk({7'h00, irq}, 8'h00);
    i_sw.rd(wdcp_pkg::C_ADDR_MASK, rd_val);
    chk(rd_val, 8'h01);
    $display("test level2 done");
    results();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("CHECK FAILED %0t run did not finish", $time);
    results();
  end
endmodule : test_watchdog_config_protection

/* File: verification/wdcp_chk_asserts.sv */
module wdcp_chk #(
  parameter int P_BASE_OSC_CYCLES = wdcp_pkg::C_BASE_OSC_CYCLES
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // Register port
  input wire logic [wdcp_pkg::C_ADDR_W-1:0] I_ADDR,
  input wire logic [wdcp_pkg::C_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [wdcp_pkg::C_DATA_W-1:0] O_RDATA,
  // Restart and fuses
  input wire logic I_WATCHDOG_RESTART_INSTR,
  input wire logic I_ALWAYS_ON_FUSE,
  // Status outputs
  input wire logic O_WDT_RESET,
  input wire logic O_WDT_ENABLED,
  input wire logic [wdcp_pkg::C_SEL_W-1:0] O_TIMEOUT_SEL,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up;
  logic [3:0] since_arm;

  // Cycles since reset release, saturating
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) up <= 4'h0;
    else if (up != 4'hF) up <= up + 4'h1;
  end

  // Cycles since the last arming write, saturating
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) since_arm <= 4'hF;
    else if (I_WR && I_ADDR == wdcp_pkg::C_ADDR_CTRL && I_WDATA[4:3] == 2'h3)
      since_arm <= 4'h0;
    else if (since_arm != 4'hF) since_arm <= since_arm + 4'h1;
  end

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_NRST);

  rst_pulse_a: assert property (O_WDT_RESET |=> !O_WDT_RESET [*4])
    else $error("watchdog reset pulse too long");
  restart_quiet_a: assert property
    (I_WATCHDOG_RESTART_INSTR |=> !O_WDT_RESET [*4])
    else $error("expiry despite restart");
  always_on_a: assert property
    (I_ALWAYS_ON_FUSE && up == 4'hF |-> O_WDT_ENABLED)
    else $error("always-on watchdog not running");
  enable_rise_a: assert property
    ($rose(O_WDT_ENABLED) && !I_ALWAYS_ON_FUSE |->
     $past(I_WR) || $past(I_WR, 2))
    else $error("watchdog enabled without a write");
  disable_armed_a: assert property
    ($fell(O_WDT_ENABLED) |-> since_arm <= 4'h6)
    else $error("watchdog disabled outside unlock window");
  sel_write_a: assert property
    ($changed(O_TIMEOUT_SEL) |-> $past(I_WR) || $past(I_WR, 2))
    else $error("prescaler changed without a write");
  rdata_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property
    (I_RD && I_ADDR > wdcp_pkg::C_ADDR_INFO |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");

  // Main scenarios
  cover property (O_WDT_RESET);
  cover property ($fell(O_WDT_ENABLED));
  cover property ($rose(O_IRQ));
endmodule : wdcp_chk

bind wdcp_top wdcp_chk #(.P_BASE_OSC_CYCLES(P_BASE_OSC_CYCLES)) i_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_WATCHDOG_RESTART_INSTR(I_WATCHDOG_RESTART_INSTR),
  .I_ALWAYS_ON_FUSE(I_ALWAYS_ON_FUSE), .O_WDT_RESET(O_WDT_RESET),
  .O_WDT_ENABLED(O_WDT_ENABLED), .O_TIMEOUT_SEL(O_TIMEOUT_SEL),
  .O_IRQ(O_IRQ)
);

/* File: verification/wdcp_sw.sv */
module wdcp_sw (
  // Clock and read data
  input wire logic i_clk,
  input wire logic [wdcp_pkg::C_DATA_W-1:0] i_rdata,
  // Bus request
  output wdcp_pkg::wdcp_bus_t o_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial o_bus = '0;

  // One-cycle write, strobe held if another follows
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    o_bus.addr <= a;
    o_bus.wdata <= d;
    o_bus.wr <= 1'b1;
    o_bus.rd <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    o_bus.addr <= a;
    o_bus.wr <= 1'b0;
    o_bus.rd <= 1'b1;
    @(posedge i_clk);
    o_bus.rd <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask : rd

  // Released bus: data lines no longer hold the last value
  // Zero cycles leaves the strobe up for a following write
  task automatic idle(input int n);
    if (n > 0) begin
      o_bus.wr <= 1'b0;
      o_bus.rd <= 1'b0;
      o_bus.wdata <= ~o_bus.wdata;
      repeat (n) @(posedge i_clk);
    end
  endtask : idle
endmodule : wdcp_sw
